//--- logic/buffer_accum_alert_params.svh
// Purpose: constants of the buffer, accumulator and alert register group
// Assumes: byte-wide registers at their printed offsets
// Notes:   included by the register bank only
//
// Functional notes
// R1: five-bit read-only buffer fill count, zero to sixteen
// R2: power-up, general call, device reset or launch bit clear counts and results
// R3: accumulator on only at 1111b, off at 0000b; host avoids other codes
// R4: each channel's 16-bit result readable as separate low and high bytes
// R5: four-bit read-only count of completed accumulations
// R6: comparator block enable bit 0, resets to zero
// R7: alert channel bits 1 and 0 enable channels 1 and 0, default off
// R8: reserved bits read zero and ignore writes
// R9: status and result registers ignore host writes
// R10: offset 0x39 holds top four bits of channel 0 high limit
// R11: offset 0x38 holds low eight bits of that 12-bit limit
// R12: fill count rises per stored result and holds at sixteen
`ifndef BUFFER_ACCUM_ALERT_PARAMS_SVH
`define BUFFER_ACCUM_ALERT_PARAMS_SVH

`define OFS_BUFFER_FILL_STATUS    8'h01
`define OFS_ACCUM_PROGRESS_STATUS 8'h02
`define OFS_ACCUM_RESULT_C0_LOW   8'h08
`define OFS_ACCUM_RESULT_C0_HIGH  8'h09
`define OFS_ACCUM_RESULT_C1_LOW   8'h0A
`define OFS_ACCUM_RESULT_C1_HIGH  8'h0B
`define OFS_ACCUM_ENABLE_CTRL     8'h30
`define OFS_ALERT_CHANNEL_ENABLES 8'h34
`define OFS_WINDOW_CMP_ENABLE     8'h37
`define OFS_UPPER_LIMIT_C0_LOW    8'h38
`define OFS_UPPER_LIMIT_C0_TOP    8'h39

`define RST_REG8                  8'h00
`define RST_FILL_COUNT            5'h00
`define RST_ACCUM_WORD            16'h0000
`define RST_NIBBLE                4'h0
`define RST_BIT                   1'b0
`define RST_PAIR                  2'b00
`define RST_LIMIT12               12'h000
`define ACCUM_CODE_OFF            4'h0
`define ACCUM_CODE_ON             4'hF
`define BUFFER_FILL_MAX           5'h10
`define WINDOW_CMP_ON_BIT         0
`define ALERT_ON_CHAN0_BIT        0
`define ALERT_ON_CHAN1_BIT        1

`endif

//--- logic/buffer_accum_alert_pkg.sv
// Purpose: shared types of the register group
// Assumes: nothing
// Notes:   constants live in the params header
package buffer_accum_alert_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [15:0] accum_word_t;
endpackage : buffer_accum_alert_pkg

//--- logic/buffer_accum_alert_regs.sv
// Purpose: buffer fill, accumulator and alert enable register group
// Assumes: host port decoded elsewhere into single-cycle read/write strobes
// Notes:   read data is registered, valid one cycle after the read strobe
`include "buffer_accum_alert_params.svh"

module buffer_accum_alert_regs #(
    parameter int ACCUM_COUNT_W = 4
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       general_call_reset_in,
    input  wire logic       device_reset_in,
    input  wire logic       sequence_launch_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    input  wire logic       result_stored_in,
    input  wire logic       accum_done_in,
    input  wire logic [15:0] accum_c0_in,
    input  wire logic [15:0] accum_c1_in,
    output logic            accum_active_out,
    output logic            window_cmp_on_out,
    output logic            alert_on_chan0_out,
    output logic            alert_on_chan1_out,
    output logic      [11:0] upper_limit_c0_out
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    // release passes two flops so every register leaves reset on one edge
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [4:0]                         buffer_fill_count;
    logic [ACCUM_COUNT_W-1:0]           accum_tally;
    // results are loaded whole from the accumulation path outside this group
    buffer_accum_alert_pkg::accum_word_t accum_c0;
    buffer_accum_alert_pkg::accum_word_t accum_c1;
    logic [3:0]                         accum_on_field;
    logic                               window_cmp_on;
    logic [1:0]                         alert_on;
    logic [3:0]                         upper_limit_c0_top_bits;
    logic [7:0]                         upper_limit_c0_low_bits;
    logic                               status_clear;
    logic                               launch_write;

    function automatic logic hit(input logic [7:0] ofs);
        hit = reg_wr_in && (reg_addr_in == ofs);
    endfunction : hit

    // one byte of a 16-bit result; both channels share this decode
    function automatic buffer_accum_alert_pkg::reg8_t byte_of(
        input buffer_accum_alert_pkg::accum_word_t word,
        input logic                                upper
    );
        byte_of = upper ? word[15:8] : word[7:0];
    endfunction : byte_of

    // only the full code turns the accumulator on; reserved codes behave as off
    function automatic logic accum_code_on(input logic [3:0] field);
        accum_code_on = (field == `ACCUM_CODE_ON);
    endfunction : accum_code_on

    // the launch bit lives in another register group; its write arrives as a strobe
    assign launch_write = sequence_launch_in;
    // a clear beats an increment in the same cycle, so a launch starts from zero
    assign status_clear = general_call_reset_in | device_reset_in | launch_write; // R2

    // ------------------------------------------------------------
    // status counters and results
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        // the count stops at sixteen; further stores are not counted
        if (!rst_sync_n)
            buffer_fill_count <= `RST_FILL_COUNT; // R2
        else if (status_clear)
            buffer_fill_count <= `RST_FILL_COUNT; // R2
        else if (result_stored_in && buffer_fill_count != `BUFFER_FILL_MAX)
            buffer_fill_count <= buffer_fill_count + 5'h01; // R1 R12
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            accum_tally <= '0;
            accum_c0    <= `RST_ACCUM_WORD;
            accum_c1    <= `RST_ACCUM_WORD;
        end
        else if (status_clear)
        begin
            accum_tally <= '0; // R2
            accum_c0    <= `RST_ACCUM_WORD;
            accum_c1    <= `RST_ACCUM_WORD;
        end
        else if (accum_done_in && accum_code_on(accum_on_field))
        begin
            // the tally wraps to zero on the sixteenth completion
            accum_tally <= accum_tally + 1'b1; // R5
            accum_c0    <= accum_c0_in; // R4
            accum_c1    <= accum_c1_in;
        end
    end

    // ------------------------------------------------------------
    // writable controls
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            accum_on_field          <= `RST_NIBBLE;
            window_cmp_on           <= `RST_BIT; // R6
            alert_on                <= `RST_PAIR; // R7
            upper_limit_c0_top_bits <= `RST_NIBBLE; // R10
            upper_limit_c0_low_bits <= `RST_REG8;
        end
        else
        begin
            // reserved bits of each write are dropped here, so they read back as zero
            if (hit(`OFS_ACCUM_ENABLE_CTRL))
                accum_on_field <= reg_wdata_in[3:0]; // R3 R8
            if (hit(`OFS_WINDOW_CMP_ENABLE))
                window_cmp_on <= reg_wdata_in[`WINDOW_CMP_ON_BIT]; // R6
            if (hit(`OFS_ALERT_CHANNEL_ENABLES))
                alert_on <= reg_wdata_in[1:0]; // R7
            if (hit(`OFS_UPPER_LIMIT_C0_TOP))
                upper_limit_c0_top_bits <= reg_wdata_in[3:0]; // R10
            if (hit(`OFS_UPPER_LIMIT_C0_LOW))
                upper_limit_c0_low_bits <= reg_wdata_in; // R11
        end
    end

    // ------------------------------------------------------------
    // read port and outputs
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00; // R8
        case (reg_addr_in)
            `OFS_BUFFER_FILL_STATUS:    next_rdata = {3'b000, buffer_fill_count}; // R1
            `OFS_ACCUM_PROGRESS_STATUS: next_rdata = {4'h0, accum_tally[3:0]}; // R5
            `OFS_ACCUM_RESULT_C0_LOW:   next_rdata = byte_of(accum_c0, 1'b0); // R4 R9
            `OFS_ACCUM_RESULT_C0_HIGH:  next_rdata = byte_of(accum_c0, 1'b1); // R4
            `OFS_ACCUM_RESULT_C1_LOW:   next_rdata = byte_of(accum_c1, 1'b0); // R4
            `OFS_ACCUM_RESULT_C1_HIGH:  next_rdata = byte_of(accum_c1, 1'b1); // R4
            `OFS_ACCUM_ENABLE_CTRL:     next_rdata = {4'h0, accum_on_field};
            `OFS_ALERT_CHANNEL_ENABLES: next_rdata = {6'h00, alert_on}; // R7
            `OFS_WINDOW_CMP_ENABLE:     next_rdata = {7'h00, window_cmp_on}; // R6
            `OFS_UPPER_LIMIT_C0_LOW:    next_rdata = upper_limit_c0_low_bits; // R11
            `OFS_UPPER_LIMIT_C0_TOP:    next_rdata = {4'h0, upper_limit_c0_top_bits}; // R10
            // unmapped offsets read zero
            default:                    next_rdata = 8'h00;
        endcase
    end

    // read data is zero whenever no read was taken, so a stale byte never lingers
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata_out <= `RST_REG8;
        else
            reg_rdata_out <= reg_rd_in ? next_rdata : `RST_REG8; // R8
    end

    // valid follows the read strobe by exactly one cycle
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rvalid_out <= `RST_BIT;
        else
            reg_rvalid_out <= reg_rd_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            accum_active_out   <= `RST_BIT;
            window_cmp_on_out  <= `RST_BIT;
            alert_on_chan0_out <= `RST_BIT;
            alert_on_chan1_out <= `RST_BIT;
        end
        else
        begin
            accum_active_out   <= accum_code_on(accum_on_field); // R3
            window_cmp_on_out  <= window_cmp_on; // R6
            alert_on_chan0_out <= alert_on[`ALERT_ON_CHAN0_BIT]; // R7
            alert_on_chan1_out <= alert_on[`ALERT_ON_CHAN1_BIT]; // R7
        end
    end

    // the 12-bit limit joins the top and low bytes in one register
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            upper_limit_c0_out <= `RST_LIMIT12;
        else
            upper_limit_c0_out <= {upper_limit_c0_top_bits, upper_limit_c0_low_bits}; // R11
    end
endmodule : buffer_accum_alert_regs

//--- test/buffer_accum_alert_checker.sv
// Purpose: port timing checks of the register group
// Assumes: single clock, one-cycle strobes, registered read data
// Notes:   bound into the bank after the module
module buffer_accum_alert_checker #(
    parameter int ACCUM_COUNT_W = 4
) (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        general_call_reset_in,
    input wire logic        result_stored_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic        accum_active_out,
    input wire logic        window_cmp_on_out,
    input wire logic        alert_on_chan0_out,
    input wire logic        alert_on_chan1_out,
    input wire logic [11:0] upper_limit_c0_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read strobe not answered next cycle");
    a_idle_rdata: assert property (!reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    a_fill_range: assert property (reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out <= 8'h10)
        else $error("fill count out of range");
    a_tally_field: assert property (reg_rd_in && reg_addr_in == 8'h02 |=> reg_rdata_out[7:4] == 4'h0)
        else $error("tally upper bits not zero");
    a_cmp_enable: assert property (reg_wr_in && reg_addr_in == 8'h37 |-> ##2
        window_cmp_on_out == $past(reg_wdata_in[0], 2)) else $error("comparator enable wrong");
    a_alert_bits: assert property (reg_wr_in && reg_addr_in == 8'h34 |-> ##2
        {alert_on_chan1_out, alert_on_chan0_out} == $past(reg_wdata_in[1:0], 2))
        else $error("alert enables wrong");
    a_accum_code: assert property (reg_wr_in && reg_addr_in == 8'h30 |-> ##2
        accum_active_out == ($past(reg_wdata_in[3:0], 2) == 4'hF)) else $error("accum code");
    a_limit_top: assert property (reg_wr_in && reg_addr_in == 8'h39 |-> ##2
        upper_limit_c0_out[11:8] == $past(reg_wdata_in[3:0], 2)) else $error("limit top");
    a_limit_low: assert property (reg_wr_in && reg_addr_in == 8'h38 |-> ##2
        upper_limit_c0_out[7:0] == $past(reg_wdata_in, 2)) else $error("limit low");
    a_clear_fill: assert property (general_call_reset_in ##1 !result_stored_in ##1
        (reg_rd_in && reg_addr_in == 8'h01) |=> reg_rdata_out == 8'h00)
        else $error("fill not cleared");
endmodule : buffer_accum_alert_checker
bind buffer_accum_alert_regs buffer_accum_alert_checker #(.ACCUM_COUNT_W(ACCUM_COUNT_W)) chk (.*);

//--- test/host_model.sv
// Purpose: host side of the register port
// Assumes: strobes change at the falling edge
// Notes:   released lines show the inverse of their last value
module host_model (
    input  wire logic       clk_in,
    output logic            wr_out    = 1'b0,
    output logic            rd_out    = 1'b0,
    output logic      [7:0] addr_out  = 8'h00,
    output logic      [7:0] wdata_out = 8'h00,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {wr_out, addr_out, wdata_out} = {1'b1, a, d};
        @(negedge clk_in);
        {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
    endtask : wr8
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        {rd_out, addr_out} = {1'b1, a};
        @(negedge clk_in);
        {rd_out, addr_out} = {1'b0, ~a};
        d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
    endtask : rd8
endmodule : host_model

//--- test/testbench.sv
// Purpose: self-checking bench of the register group
// Assumes: xorshift stimulus from a fixed seed
// Notes:   port timing is checked by the bound checker
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] rw_ofs [5] = '{8'h30, 8'h34, 8'h37, 8'h38, 8'h39};
    localparam logic [7:0] rw_msk [5] = '{8'h0F, 8'h03, 8'h01, 8'hFF, 8'h0F};
    localparam logic [7:0] ro_ofs [7] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h50};
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, stored = 1'b0, done = 1'b0;
    logic gcr = 1'b0, dev = 1'b0, seq = 1'b0;
    logic [15:0] c0 = 16'h0000, c1 = 16'h0000;
    logic wr, rd, rvalid;
    logic [7:0] addr, wdata, rdata;
    logic [31:0] seed = 32'h00000044;
    int error_cnt = 0, n_tests = 0;
    always #5 core_clk_in = ~core_clk_in;
    host_model host (.clk_in(core_clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
    buffer_accum_alert_regs #(.ACCUM_COUNT_W(4)) uut (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .general_call_reset_in(gcr), .device_reset_in(dev),
        .sequence_launch_in(seq), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .result_stored_in(stored), .accum_done_in(done), .accum_c0_in(c0), .accum_c1_in(c1),
        .accum_active_out(), .window_cmp_on_out(), .alert_on_chan0_out(),
        .alert_on_chan1_out(), .upper_limit_c0_out());
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [7:0] exp_fill(int n);
        return (n > 16) ? 8'h10 : 8'(n);
    endfunction : exp_fill
    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd8(a, d);
        n_tests++;
        if (d !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, d, e);
            error_cnt++;
        end
    endtask : rc
    task automatic ev(ref logic s);
        @(negedge core_clk_in);
        s = 1'b1;
        @(negedge core_clk_in);
        s = 1'b0;
    endtask : ev
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        error_cnt++;
        final_report();
    end
    initial
    begin
        logic [7:0] d;
        int n;
        repeat (16) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        foreach (ro_ofs[i]) rc(ro_ofs[i], 8'h00);
        foreach (rw_ofs[i]) rc(rw_ofs[i], 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 15; i++)
        begin
            d = 8'(xs());
            if (i % 5 == 0) d = d[0] ? 8'hFF : 8'h00;
            host.wr8(rw_ofs[i % 5], d);
            rc(rw_ofs[i % 5], d & rw_msk[i % 5]);
            host.wr8(ro_ofs[i % 7], d);
            rc(ro_ofs[i % 7], 8'h00);
        end
        $display("test register access done");
        for (int j = 0; j < 3; j++)
        begin
            host.wr8(8'h30, (j == 1) ? 8'h00 : 8'h0F);
            n = (j == 0) ? 18 : int'(xs() % 16);
            repeat (n) ev(stored);
            c0 = 16'(xs());
            c1 = 16'(xs());
            ev(done);
            if (j == 1) {c0, c1} = 32'h00000000;
            rc(8'h01, exp_fill(n));
            rc(8'h02, (j == 1) ? 8'h00 : 8'h01);
            rc(8'h08, c0[7:0]);
            rc(8'h09, c0[15:8]);
            rc(8'h0A, c1[7:0]);
            rc(8'h0B, c1[15:8]);
            case (j)
                0: ev(gcr);
                1: ev(dev);
                default: ev(seq);
            endcase
            for (int k = 0; k < 6; k++) rc(ro_ofs[k], 8'h00);
        end
        $display("test fill accumulate clear done");
        // accumulator still on: two completions, then clear and events in one cycle
        ev(done);
        ev(done);
        rc(8'h02, 8'h02);
        @(negedge core_clk_in);
        {stored, done, seq} = 3'b111;
        @(negedge core_clk_in);
        {stored, done, seq} = 3'b000;
        rc(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        rc(8'h08, 8'h00);
        rc(8'h0B, 8'h00);
        $display("test clear priority done");
        final_report();
    end
endmodule : testbench
